/* hdl/ptpwm_defs.svh */
// Offsets, field positions, reset values and timing counts of the pulse output block.
`ifndef PTPWM_DEFS_SVH
`define PTPWM_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PTPWM_CLK_NS 32'h0000_0005
`define PTPWM_US_NS 32'h0000_03E8
`define PTPWM_MS_NS 32'h000F_4240
`define PTPWM_US_HALF (`PTPWM_US_NS / `PTPWM_CLK_NS / 32'h0000_0002)
`define PTPWM_MS_HALF (`PTPWM_MS_NS / `PTPWM_CLK_NS / 32'h0000_0002)
`define PTPWM_US_MIN 16'h0032
`define PTPWM_MS_MIN 16'h0002

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PTPWM_CTRL 5'h00
`define PTPWM_CYCLE 5'h04
`define PTPWM_WIDTH 5'h08
`define PTPWM_COUNT 5'h0C
`define PTPWM_NSEG 5'h10
`define PTPWM_PADDR 5'h14
`define PTPWM_PCYCLE 5'h18
`define PTPWM_PCOUNT 5'h1C
`define PTPWM_STATUS 8'h40
`define PTPWM_CTRL_MODE 0
`define PTPWM_CTRL_MS 1
`define PTPWM_CTRL_PROF 2
`define PTPWM_CTRL_RUN 3
`define PTPWM_NSEG_RST 8'h01

`endif

/* hdl/ptpwm_pkg.sv */
// Types shared by the pulse output block.
package ptpwm_pkg;
  typedef enum logic [1:0] {
    ptpwm_idle = 2'b00,
    ptpwm_train = 2'b01,
    ptpwm_pwm = 2'b10
  } ptpwm_state_e;
  typedef enum logic {
    ptpwm_pulse_train_mode = 1'b0,
    ptpwm_pwm_mode = 1'b1
  } ptpwm_mode_e;
endpackage : ptpwm_pkg

/* hdl/ptpwm_chan.sv */
// One pulse output engine: time base, pulse train with segments, and PWM.
`timescale 1ns/1ps
`default_nettype none
`include "ptpwm_defs.svh"

module ptpwm_chan
  import ptpwm_pkg::*;
#(
  parameter logic [16:0] MS_HALF = 17'(`PTPWM_MS_HALF)
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic pwm_mode_in,
  input wire logic ms_base_in,
  input wire logic [15:0] cycle_in,
  input wire logic [15:0] width_in,
  input wire logic [31:0] count_in,
  input wire logic [7:0] nseg_in,
  output logic [7:0] seg_idx_out,
  output logic pin_out,
  output logic busy_out,
  output logic done_out
);
  // ----------------------------------------------------------------------
  // Time base and period arithmetic
  // ----------------------------------------------------------------------
  ptpwm_state_e state;
  logic [16:0] pre_cnt;
  logic [16:0] half_cnt;
  logic [31:0] pulse_cnt;
  logic [16:0] limit;
  logic [15:0] eff_cyc;
  logic tick;
  logic period_end;
  logic seg_last_pulse;
  logic last_seg;

  // Counting half units keeps the train at exactly half duty for odd cycle values.
  assign limit = ms_base_in ? MS_HALF : 17'(`PTPWM_US_HALF);
  assign eff_cyc = (cycle_in < (ms_base_in ? `PTPWM_MS_MIN : `PTPWM_US_MIN)) ?
                   (ms_base_in ? `PTPWM_MS_MIN : `PTPWM_US_MIN) : cycle_in;
  assign tick = (pre_cnt == limit - 17'h00001);
  assign period_end = tick && (half_cnt == {eff_cyc, 1'b0} - 17'h00001);
  // A zero count is treated as one pulse so a train always ends.
  assign seg_last_pulse = (count_in == 32'h0000_0000) ||
                          (pulse_cnt == count_in - 32'h0000_0001);
  assign last_seg = ({1'b0, seg_idx_out} + 9'h001) >= {1'b0, nseg_in};
  assign busy_out = (state != ptpwm_idle);

  // Prescaler and half-unit counter run only while an output is active.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || state == ptpwm_idle || tick) pre_cnt <= 17'h00000;
    else pre_cnt <= pre_cnt + 17'h00001;
    if (!rstn_in || state == ptpwm_idle || period_end) half_cnt <= 17'h00000;
    else if (tick) half_cnt <= half_cnt + 17'h00001;
  end

  // ----------------------------------------------------------------------
  // Mode sequencing, pulse and segment counting
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    done_out <= 1'b0;
    if (!rstn_in) state <= ptpwm_idle;
    else case (state)
      ptpwm_idle: if (start_in) state <= pwm_mode_in ? ptpwm_pwm : ptpwm_train;
      ptpwm_train:
        if (stop_in) state <= ptpwm_idle;
        else if (period_end && seg_last_pulse && last_seg)
        begin
          state <= ptpwm_idle;
          done_out <= 1'b1;
        end
      ptpwm_pwm: if (stop_in) state <= ptpwm_idle;
      default: state <= ptpwm_idle;
    endcase
  end

  // Segments follow each other on the period boundary, so a profile has no gaps.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || state != ptpwm_train)
    begin
      pulse_cnt <= 32'h0000_0000;
      seg_idx_out <= 8'h00;
    end
    else if (period_end)
    begin
      pulse_cnt <= seg_last_pulse ? 32'h0000_0000 : pulse_cnt + 32'h0000_0001;
      if (seg_last_pulse && !last_seg) seg_idx_out <= seg_idx_out + 8'h01;
    end
  end

  // The pin is registered so it never glitches on counter transitions.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in) pin_out <= 1'b0;
    else case (state)
      ptpwm_train: pin_out <= (half_cnt < {1'b0, eff_cyc});
      ptpwm_pwm: pin_out <= (half_cnt < {width_in, 1'b0});
      default: pin_out <= 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [31:0] hi_len;
  logic [31:0] rise_cnt;
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !pin_out) hi_len <= 32'h0000_0000;
    else hi_len <= hi_len + 32'h0000_0001;
    if (!rstn_in || state == ptpwm_idle) rise_cnt <= 32'h0000_0000;
    else if (state == ptpwm_train && pin_out && hi_len == 32'h0000_0000)
      rise_cnt <= rise_cnt + 32'h0000_0001;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence start_seq;
    state == ptpwm_idle && start_in;
  endsequence

  start_mode_a: assert property (start_seq ##0 pwm_mode_in |=> state == ptpwm_pwm)
    else $error("pwm start did not enter pwm state");
  // The high-time counter starts at zero, so the last high cycle holds the length minus one.
  train_half_a: assert property ($fell(pin_out) && state == ptpwm_train
    && $past(state) == ptpwm_train
    |-> $past(hi_len) + 32'h0000_0001 == 32'(eff_cyc) * 32'(limit))
    else $error("train high time is not half the cycle");
  done_count_a: assert property (done_out && nseg_in <= 8'h01
    && count_in != 32'h0000_0000 |-> $past(rise_cnt) == count_in)
    else $error("train pulse count mismatch");
  seg_step_a: assert property (state == ptpwm_train && $past(state) == ptpwm_train
    && seg_idx_out != $past(seg_idx_out) |-> seg_idx_out == 8'($past(seg_idx_out) + 8'h01))
    else $error("segment index skipped");
  pwm_full_a: assert property (state == ptpwm_pwm && width_in >= eff_cyc
    |=> pin_out) else $error("full duty output not high");
  pwm_zero_a: assert property (state == ptpwm_pwm && width_in == 16'h0000
    |=> !pin_out) else $error("zero duty output not low");
  idle_low_a: assert property (done_out |-> ##1 !pin_out [*2])
    else $error("output not low after train end");
  // The measured high time, not the clamp, is held against the shortest legal cycle.
  cyc_floor_a: assert property ($fell(pin_out) && state == ptpwm_train
    && $past(state) == ptpwm_train
    |-> $past(hi_len) + 32'h0000_0001 >=
        (ms_base_in ? 32'(`PTPWM_MS_MIN) : 32'(`PTPWM_US_MIN)) * 32'(limit))
    else $error("cycle below minimum");
endmodule : ptpwm_chan
`default_nettype wire

/* hdl/ptpwm_top.sv */
// Two-output pulse train and PWM generator with its register port.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptpwm_defs.svh"

module ptpwm_top
  import ptpwm_pkg::*;
#(
  parameter logic [16:0] MS_HALF = 17'(`PTPWM_MS_HALF)
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic first_pulse_output_out,
  output logic second_pulse_output_out
);
  // ----------------------------------------------------------------------
  // Shared decode and status
  // ----------------------------------------------------------------------
  logic [1:0] pin;
  logic [1:0] busy;
  logic [1:0] done_pulse;
  logic [1:0] done;
  logic [31:0] ch_rd [0:1];
  logic status_wr;

  assign status_wr = wr_in && (addr_in == `PTPWM_STATUS);
  assign first_pulse_output_out = pin[0];
  assign second_pulse_output_out = pin[1];

  // Completion flags are sticky and cleared by writing one; a new completion wins.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in) done <= 2'h0;
    else done <= done_pulse | (done & ~(status_wr ? wdata_in[1:0] : 2'h0));
  end

  // ----------------------------------------------------------------------
  // Per-output registers, profile table and engine
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic ctrl_mode;
    logic ctrl_ms;
    logic ctrl_prof;
    logic [15:0] cycle;
    logic [15:0] width;
    logic [31:0] count;
    logic [7:0] nseg;
    logic [7:0] paddr;
    logic [15:0] prof_cyc [0:255];
    logic [31:0] prof_cnt [0:255];
    logic [7:0] seg_idx;
    logic sel;
    logic [4:0] off;
    logic start;
    logic stop;
    logic [15:0] eng_cyc;
    logic [31:0] eng_cnt;
    logic [7:0] eng_nseg;
    logic mode_now;

    assign off = addr_in[4:0];
    assign sel = wr_in && (addr_in[7:6] == 2'h0) && (addr_in[5] == 1'(ch));
    // Writing the run bit starts an idle output; clearing it stops a running one.
    assign start = sel && off == `PTPWM_CTRL && wdata_in[`PTPWM_CTRL_RUN] && !busy[ch];
    assign stop = sel && off == `PTPWM_CTRL && !wdata_in[`PTPWM_CTRL_RUN];

    // Control and single-train settings.
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        ctrl_mode <= 1'b0;
        ctrl_ms <= 1'b0;
        ctrl_prof <= 1'b0;
        cycle <= `PTPWM_US_MIN;
        width <= 16'h0000;
        count <= 32'h0000_0001;
        nseg <= `PTPWM_NSEG_RST;
      end
      else if (sel)
      begin
        case (off)
          `PTPWM_CTRL:
          begin
            // Mode and base are frozen while running to keep a burst coherent.
            if (!busy[ch])
            begin
              ctrl_mode <= wdata_in[`PTPWM_CTRL_MODE];
              ctrl_ms <= wdata_in[`PTPWM_CTRL_MS];
              ctrl_prof <= wdata_in[`PTPWM_CTRL_PROF];
            end
          end
          `PTPWM_CYCLE: cycle <= wdata_in[15:0];
          `PTPWM_WIDTH: width <= wdata_in[15:0];
          `PTPWM_COUNT: count <= wdata_in[31:0];
          `PTPWM_NSEG: nseg <= wdata_in[7:0];
          default: ;
        endcase
      end
    end

    // Profile table pointer; a count write advances it to ease loading in order.
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in) paddr <= 8'h00;
      else if (sel && off == `PTPWM_PADDR) paddr <= wdata_in[7:0];
      else if (sel && off == `PTPWM_PCOUNT) paddr <= paddr + 8'h01;
    end

    // The profile table has no reset, software loads it before use.
    always_ff @(posedge clk_in)
    begin
      if (sel && off == `PTPWM_PCYCLE) prof_cyc[paddr] <= wdata_in[15:0];
      if (sel && off == `PTPWM_PCOUNT) prof_cnt[paddr] <= wdata_in[31:0];
    end

    // The engine reads the current segment directly, so the next one is ready at once.
    assign eng_cyc = ctrl_prof ? prof_cyc[seg_idx] : cycle;
    assign eng_cnt = ctrl_prof ? prof_cnt[seg_idx] : count;
    assign eng_nseg = ctrl_prof ? nseg : 8'h01;
    // The run write carries the mode it starts in; the mode register only follows a cycle later.
    assign mode_now = start ? wdata_in[`PTPWM_CTRL_MODE] : ctrl_mode;

    ptpwm_chan #(
      .MS_HALF(MS_HALF)
    ) u_chan (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .start_in(start),
      .stop_in(stop),
      .pwm_mode_in(mode_now),
      .ms_base_in(ctrl_ms),
      .cycle_in(eng_cyc),
      .width_in(width),
      .count_in(eng_cnt),
      .nseg_in(eng_nseg),
      .seg_idx_out(seg_idx),
      .pin_out(pin[ch]),
      .busy_out(busy[ch]),
      .done_out(done_pulse[ch])
    );

    // Read view of this output's registers.
    always_comb
    begin
      ch_rd[ch] = 32'h0000_0000;
      case (off)
        `PTPWM_CTRL: ch_rd[ch] = {28'h0, busy[ch], ctrl_prof, ctrl_ms, ctrl_mode};
        `PTPWM_CYCLE: ch_rd[ch] = {16'h0000, cycle};
        `PTPWM_WIDTH: ch_rd[ch] = {16'h0000, width};
        `PTPWM_COUNT: ch_rd[ch] = count;
        `PTPWM_NSEG: ch_rd[ch] = {24'h00_0000, nseg};
        `PTPWM_PADDR: ch_rd[ch] = {16'h0000, seg_idx, paddr};
        `PTPWM_PCYCLE: ch_rd[ch] = {16'h0000, prof_cyc[paddr]};
        `PTPWM_PCOUNT: ch_rd[ch] = prof_cnt[paddr];
        default: ch_rd[ch] = 32'h0000_0000;
      endcase
    end

    width_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      sel && off == `PTPWM_WIDTH |=> width == $past(wdata_in[15:0]))
      else $error("width register did not load");
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Read data stand only in the cycle after the strobe; unmapped words read zero.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !rd_in) rdata_out <= 32'h0000_0000;
    else if (addr_in[7:6] == 2'h0) rdata_out <= ch_rd[addr_in[5]];
    else if (addr_in == `PTPWM_STATUS) rdata_out <= {28'h0, busy, done};
    else rdata_out <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence done_rise(int c);
    done_pulse[c] ##1 done[c];
  endsequence

  // Both outputs are watched, since each raises a completion flag of its own.
  for (genvar c = 0; c < 2; c++)
  begin : g_chk
    done_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      done_pulse[c] |-> done_rise(c)) else $error("completion flag not raised");
    done_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_in && addr_in == `PTPWM_STATUS && done[c] |=> rdata_out[c])
      else $error("completion flag not visible on read");
  end
endmodule : ptpwm_top
`default_nettype wire

/* tb/ptpwm_drive_model.sv */
// Stepper drive stand-in that counts and times the pulses on one output pin.
`timescale 1ns/1ps
`default_nettype none

module ptpwm_drive_model
(
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic step_in,
  output int pulses_out,
  output int high_out,
  output int low_out,
  output int span_out
);
  logic prev = 1'b0;
  int run = 0;
  int cyc = 0;
  int first = 0;

  // A drive sees only edges, so each level is timed from one edge to the next.
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (clr_in)
    begin
      pulses_out <= 0;
      high_out <= 0;
      low_out <= 0;
      span_out <= 0;
      run <= 1;
      prev <= step_in;
    end
    else if (step_in !== prev)
    begin
      run <= 1;
      prev <= step_in;
      if (prev)
      begin
        high_out <= run;
        span_out <= cyc - first;
      end
      else
      begin
        low_out <= run;
        pulses_out <= pulses_out + 1;
        if (pulses_out == 0)
          first <= cyc;
      end
    end
    else
      run <= run + 1;
  end
endmodule : ptpwm_drive_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the two-output pulse train and PWM block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic clr = 1'b1;
  logic [31:0] rdata_out;
  logic pin0;
  logic pin1;
  logic [31:0] d;
  int p0, h0, l0, s0, p1, h1, l1;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  // --------------------------------------------------------------------
  // Clock, design and drive models
  // --------------------------------------------------------------------
  always #2.5 clk_in = ~clk_in;

  // A short millisecond keeps long trains affordable in simulation.
  ptpwm_top #(.MS_HALF(17'h0000A)) u_ptpwm_top (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .first_pulse_output_out(pin0), .second_pulse_output_out(pin1));
  ptpwm_drive_model u_ptpwm_drive_model (.clk_in(clk_in), .clr_in(clr), .step_in(pin0),
    .pulses_out(p0), .high_out(h0), .low_out(l0), .span_out(s0));
  ptpwm_drive_model u_ptpwm_drive_model_1 (.clk_in(clk_in), .clr_in(clr), .step_in(pin1),
    .pulses_out(p1), .high_out(h1), .low_out(l1), .span_out());

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task conclude;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    v = rdata_out;
  endtask : rd

  task wait_done(input logic [31:0] m);
    for (int n = 0; n < 8000; n++)
    begin
      rd(8'h40, d);
      if ((d & m) !== 32'h0000_0000)
        break;
    end
    chk(d & m, m);
  endtask : wait_done

  task clear_model;
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
  endtask : clear_model

  // A hung poll must still end the run with a verdict.
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      conclude();
    end
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Reset values, then an unmapped place that must read zero.
    rd(8'h04, d);
    chk(d, 32'h0000_0032);
    rd(8'h08, d);
    chk(d, 32'h0000_0000);
    rd(8'h0C, d);
    chk(d, 32'h0000_0001);
    rd(8'h10, d);
    chk(d, 32'h0000_0001);
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h44, d);
    chk(d, 32'h0000_0000);
    // Train of three on the first pin while the second runs PWM.
    wr(8'h04, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0003);
    wr(8'h24, 32'h0000_0004);
    wr(8'h28, 32'h0000_0001);
    clear_model();
    wr(8'h20, 32'h0000_000B);
    wr(8'h00, 32'h0000_000A);
    rd(8'h40, d);
    chk(d, 32'h0000_000C);
    wait_done(32'h0000_0001);
    chk(p0, 32'h0000_0003);
    chk(h0, 32'h0000_001E);
    chk(l0, 32'h0000_001E);
    chk({31'h0, pin0}, 32'h0000_0000);
    chk(h1, 32'h0000_0014);
    chk(l1, 32'h0000_003C);
    rd(8'h40, d);
    chk(d, 32'h0000_0009);
    wr(8'h40, 32'h0000_0001);
    rd(8'h40, d);
    chk(d, 32'h0000_0008);
    // Width equal to the period, then zero, changed while running.
    wr(8'h28, 32'h0000_0004);
    repeat (100) @(posedge clk_in);
    clear_model();
    repeat (200) @(posedge clk_in);
    chk(p1, 32'h0000_0000);
    chk({31'h0, pin1}, 32'h0000_0001);
    wr(8'h28, 32'h0000_0000);
    repeat (100) @(posedge clk_in);
    clear_model();
    repeat (200) @(posedge clk_in);
    chk(p1, 32'h0000_0000);
    chk({31'h0, pin1}, 32'h0000_0000);
    wr(8'h20, 32'h0000_0000);
    rd(8'h40, d);
    chk(d, 32'h0000_0000);
    // Two-segment profile: two pulses of 2 ms then one of 4 ms, no gap.
    wr(8'h10, 32'h0000_0002);
    wr(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_0002);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h18, 32'h0000_0004);
    wr(8'h1C, 32'h0000_0001);
    clear_model();
    wr(8'h00, 32'h0000_000E);
    wait_done(32'h0000_0001);
    chk(p0, 32'h0000_0003);
    chk(h0, 32'h0000_0028);
    chk(s0, 32'h0000_0078);
    wr(8'h40, 32'h0000_0001);
    // The second pin leaves PWM for a train of two on its own, started by one write.
    wr(8'h24, 32'h0000_0002);
    wr(8'h2C, 32'h0000_0002);
    clear_model();
    wr(8'h20, 32'h0000_000A);
    wait_done(32'h0000_0002);
    chk(p1, 32'h0000_0002);
    chk(h1, 32'h0000_0014);
    chk(l1, 32'h0000_0014);
    chk({31'h0, pin1}, 32'h0000_0000);
    rd(8'h40, d);
    chk(d, 32'h0000_0002);
    wr(8'h40, 32'h0000_0002);
    // A cycle below the microsecond minimum runs at the minimum.
    wr(8'h04, 32'h0000_000A);
    wr(8'h0C, 32'h0000_0001);
    clear_model();
    wr(8'h00, 32'h0000_0008);
    wait_done(32'h0000_0001);
    chk(p0, 32'h0000_0001);
    chk(h0, 32'h0000_1388);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
